// ### src/rbx_pkg.sv
// Package for the relative branch and bit set execution block.
// Assumes a core that fetches one 16-bit word per instruction cycle.
package rbx_pkg;
    // ---------------------------------------------------------------
    // Opcode fields
    // ---------------------------------------------------------------
    localparam logic [7:0]  OPC_BRANCH_IF_NEGATIVE     = 8'hE6;
    localparam logic [7:0]  OPC_BRANCH_IF_NO_CARRY     = 8'hE3;
    localparam logic [7:0]  OPC_BRANCH_IF_NOT_NEGATIVE = 8'hE7;
    localparam logic [7:0]  OPC_BRANCH_IF_NO_OVERFLOW  = 8'hE5;
    localparam logic [7:0]  OPC_BRANCH_IF_NONZERO      = 8'hE1;
    localparam logic [4:0]  OPC_BRANCH_ALWAYS          = 5'h1A;
    localparam logic [3:0]  OPC_SET_REGISTER_BIT       = 4'h8;
    localparam int          BIT_IDX_LSB                = 9;
    localparam int          BANK_BIT                   = 8;
    // ---------------------------------------------------------------
    // Addressing
    // ---------------------------------------------------------------
    localparam logic [7:0]  INDEXED_LIMIT              = 8'h5F;
    localparam logic [7:0]  ACCESS_SPLIT               = 8'h60;
    localparam logic [3:0]  ACCESS_HIGH_BANK           = 4'hF;
    // ---------------------------------------------------------------
    // Register map (word byte addresses)
    // ---------------------------------------------------------------
    localparam logic [7:0]  ADDR_CTRL                  = 8'h00;
    localparam logic [7:0]  ADDR_STATUS                = 8'h04;
    localparam logic [7:0]  ADDR_PC                    = 8'h08;
    localparam logic [7:0]  ADDR_COUNT                 = 8'h0C;
    localparam logic [31:0] CTRL_RESET                 = 32'h0000_0000;
    localparam int          CTRL_EXT_BIT               = 0;
    localparam int          CTRL_BANK_LSB              = 4;
    localparam logic [20:0] PC_RESET                   = 21'h00_0000;

    typedef enum logic [1:0] {PH_DECODE, PH_READ, PH_PROCESS, PH_WRITE} rbx_phase_type;
endpackage

// ### src/rbx_bus.sv
// AHB-Lite slave register file for the execution block.
// Assumes a single master, single word transfers, hready tied to hreadyout.
`timescale 1ns/1ps
module rbx_bus
(
    input  wire logic        clk_in,
    input  wire logic        resetn_in,
    input  wire logic        hsel_in,
    input  wire logic [7:0]  haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic        hready_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic [31:0] status_in,
    input  wire logic [20:0] pc_in,
    input  wire logic [31:0] count_in,
    output logic      [31:0] hrdata_out,
    output logic      [31:0] ctrl_out
);
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] ctrl;
        logic [31:0] rdata;
    } rbx_bus_type;

    rbx_bus_type st_ff;
    rbx_bus_type nxt_st;
    logic        take;

    assign take = hsel_in && hready_in && htrans_in[1];

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.wr = take && hwrite_in;
        nxt_st.rd = take && !hwrite_in;
        if (take)
        begin
            nxt_st.addr = haddr_in;
        end
        if (st_ff.wr && st_ff.addr == rbx_pkg::ADDR_CTRL)
        begin
            nxt_st.ctrl = hwdata_in;
        end
        // Read data is captured at the address phase, so unmapped reads give zero
        if (take && !hwrite_in)
        begin
            case (haddr_in)
                rbx_pkg::ADDR_CTRL:   nxt_st.rdata = st_ff.ctrl;
                rbx_pkg::ADDR_STATUS: nxt_st.rdata = status_in;
                rbx_pkg::ADDR_PC:     nxt_st.rdata = {11'h000, pc_in};
                rbx_pkg::ADDR_COUNT:  nxt_st.rdata = count_in;
                default:              nxt_st.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            st_ff <= '{wr: 1'b0, rd: 1'b0, addr: 8'h00, ctrl: rbx_pkg::CTRL_RESET, rdata: 32'h0000_0000};
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign hrdata_out = st_ff.rdata;
    assign ctrl_out   = st_ff.ctrl;
endmodule // rbx_bus

// ### src/rbx_exec.sv
// Execution unit for relative branches and the register bit set.
// Assumes the fetch side presents one instruction word per cycle with a valid strobe,
// and that data memory answers a read in the same cycle it is addressed.
//
// How it works
// - A branch_if_negative word (E6) moves the program counter only when N is one.
// - A branch_if_no_carry word (E3) moves the program counter only when C is zero.
// - A branch_if_not_negative word (E7) moves the program counter only when N is zero.
// - A branch_if_no_overflow word (E5) moves the program counter only when OV is zero.
// - A branch_if_nonzero word (E1) moves the program counter only when Z is zero.
// - A taken branch loads the incremented counter plus twice the sign-extended offset.
// - Conditional branches take one cycle untaken and two taken, offsets -128 to 127.
// - Phases run decode, read, process, write; a taken branch then spends a dead cycle.
// - The branch_always word (11010 plus 11-bit offset) always jumps and takes two cycles.
// - The set_register_bit word forces one chosen bit of the addressed byte to one.
// - Bank operand zero selects the access bank, one takes the bank from bank_select_reg.
// - With bank operand zero and the extended set on, addresses up to 95 are indexed.
//
// Added by the designer: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
module rbx_exec
#(
    parameter int PC_W = 21
)
(
    input  wire logic        CLK_IN,
    input  wire logic        RESETN_IN,
    input  wire logic        HSEL_IN,
    input  wire logic [7:0]  HADDR_IN,
    input  wire logic [1:0]  HTRANS_IN,
    input  wire logic        HWRITE_IN,
    input  wire logic [2:0]  HSIZE_IN,
    input  wire logic        HREADY_IN,
    input  wire logic [31:0] HWDATA_IN,
    output logic      [31:0] HRDATA_OUT,
    output logic             HREADYOUT_OUT,
    output logic             HRESP_OUT,
    input  wire logic        INSTR_VALID_IN,
    input  wire logic [15:0] INSTR_IN,
    input  wire logic        FLAG_N_IN,
    input  wire logic        FLAG_OV_IN,
    input  wire logic        FLAG_Z_IN,
    input  wire logic        FLAG_C_IN,
    input  wire logic [11:0] FSR2_IN,
    input  wire logic [7:0]  MEM_RDATA_IN,
    output logic             INSTR_READY_OUT,
    output logic [PC_W-1:0]  PC_OUT,
    output logic [11:0]      MEM_ADDR_OUT,
    output logic             MEM_WE_OUT,
    output logic [7:0]       MEM_WDATA_OUT,
    output logic             FLAGS_WE_OUT
);
    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef struct packed {
        rbx_pkg::rbx_phase_type phase;
        logic                   nop_cycle;
        logic                   busy;
        logic [15:0]            instr;
        logic                   taken;
        logic                   is_setbit;
        logic [PC_W-1:0]        pc;
        logic [PC_W-1:0]        target;
        logic [11:0]            maddr;
        logic [7:0]             wdata;
        logic                   we;
        logic [31:0]            count;
    } rbx_state_type;

    rbx_state_type st_ff;
    rbx_state_type nxt_st;

    logic [31:0] ctrl;
    logic [31:0] status;
    logic        ext_en;
    logic [3:0]  bank_sel;
    logic        cond_op;
    logic        cond_ok;
    logic        is_always;
    logic        is_setbit_w;
    logic [PC_W-1:0] offset;
    logic [11:0] ea;
    logic [7:0]  faddr;
    logic [2:0]  bidx;

    assign ext_en   = ctrl[rbx_pkg::CTRL_EXT_BIT];
    assign bank_sel = ctrl[rbx_pkg::CTRL_BANK_LSB +: 4];
    assign status   = {28'h0000_000, st_ff.taken, st_ff.nop_cycle, st_ff.phase};

    // ---------------------------------------------------------------
    // Register bus
    // ---------------------------------------------------------------
    rbx_bus u_bus
    (
        .clk_in     (CLK_IN),
        .resetn_in  (RESETN_IN),
        .hsel_in    (HSEL_IN),
        .haddr_in   (HADDR_IN),
        .htrans_in  (HTRANS_IN),
        .hwrite_in  (HWRITE_IN),
        .hready_in  (HREADY_IN),
        .hwdata_in  (HWDATA_IN),
        .status_in  (status),
        .pc_in      (PC_OUT[20:0]),
        .count_in   (st_ff.count),
        .hrdata_out (HRDATA_OUT),
        .ctrl_out   (ctrl)
    );
    assign HREADYOUT_OUT = 1'b1;
    assign HRESP_OUT     = 1'b0;

    // ---------------------------------------------------------------
    // Decode
    // ---------------------------------------------------------------
    // Flags are read live at process time, never copied, so no stale condition
    always_comb
    begin
        cond_op = 1'b1;
        cond_ok = 1'b0;
        case (st_ff.instr[15:8])
            rbx_pkg::OPC_BRANCH_IF_NEGATIVE:     cond_ok = FLAG_N_IN;
            rbx_pkg::OPC_BRANCH_IF_NO_CARRY:     cond_ok = !FLAG_C_IN;
            rbx_pkg::OPC_BRANCH_IF_NOT_NEGATIVE: cond_ok = !FLAG_N_IN;
            rbx_pkg::OPC_BRANCH_IF_NO_OVERFLOW:  cond_ok = !FLAG_OV_IN;
            rbx_pkg::OPC_BRANCH_IF_NONZERO:      cond_ok = !FLAG_Z_IN;
            default:                             cond_op = 1'b0;
        endcase
    end

    localparam int BIT_HI = rbx_pkg::BIT_IDX_LSB + 2;
    assign is_always   = st_ff.instr[15:11] == rbx_pkg::OPC_BRANCH_ALWAYS;
    assign is_setbit_w = st_ff.instr[15:12] == rbx_pkg::OPC_SET_REGISTER_BIT;
    assign faddr       = st_ff.instr[7:0];
    assign bidx        = st_ff.instr[BIT_HI:rbx_pkg::BIT_IDX_LSB];

    // Offset in words, doubled to bytes
    always_comb
    begin
        if (is_always)
        begin
            offset = {{(PC_W-12){st_ff.instr[10]}}, st_ff.instr[10:0], 1'b0};
        end
        else
        begin
            offset = {{(PC_W-9){st_ff.instr[7]}}, st_ff.instr[7:0], 1'b0};
        end
    end

    // Effective data address
    always_comb
    begin
        if (st_ff.instr[rbx_pkg::BANK_BIT])
        begin
            ea = {bank_sel, faddr};
        end
        else if (ext_en && faddr <= rbx_pkg::INDEXED_LIMIT)
        begin
            ea = 12'(FSR2_IN + {4'h0, faddr});
        end
        else if (faddr < rbx_pkg::ACCESS_SPLIT)
        begin
            ea = {4'h0, faddr};
        end
        else
        begin
            ea = {rbx_pkg::ACCESS_HIGH_BANK, faddr};
        end
    end

    // ---------------------------------------------------------------
    // Phase sequencer
    // ---------------------------------------------------------------
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.we = 1'b0;
        case (st_ff.phase)
            rbx_pkg::PH_DECODE:
            begin
                if (st_ff.nop_cycle)
                begin
                    // Dead cycle after a jump keeps ready low and accepts no word
                    nxt_st.phase = rbx_pkg::PH_READ;
                end
                else if (INSTR_VALID_IN)
                begin
                    nxt_st.instr = INSTR_IN;
                    nxt_st.busy  = 1'b1;
                    nxt_st.pc    = PC_W'(st_ff.pc + 2);
                    nxt_st.phase = rbx_pkg::PH_READ;
                end
            end
            rbx_pkg::PH_READ:
            begin
                nxt_st.is_setbit = is_setbit_w && !st_ff.nop_cycle;
                nxt_st.maddr  = ea;
                nxt_st.phase  = rbx_pkg::PH_PROCESS;
            end
            rbx_pkg::PH_PROCESS:
            begin
                nxt_st.taken  = !st_ff.nop_cycle && (is_always || (cond_op && cond_ok));
                nxt_st.target = PC_W'(st_ff.pc + offset);
                nxt_st.wdata  = MEM_RDATA_IN | (8'h01 << bidx);
                nxt_st.phase  = rbx_pkg::PH_WRITE;
            end
            rbx_pkg::PH_WRITE:
            begin
                nxt_st.phase = rbx_pkg::PH_DECODE;
                nxt_st.busy  = 1'b0;
                if (st_ff.nop_cycle)
                begin
                    nxt_st.nop_cycle = 1'b0;
                    nxt_st.count     = 32'(st_ff.count + 1);
                end
                else if (st_ff.taken)
                begin
                    nxt_st.pc        = st_ff.target;
                    nxt_st.nop_cycle = 1'b1;
                    nxt_st.taken     = 1'b0;
                end
                else
                begin
                    // Untaken branch keeps the incremented PC and still bumps the count
                    nxt_st.we    = st_ff.is_setbit;
                    nxt_st.count = 32'(st_ff.count + 1);
                end
                nxt_st.is_setbit = 1'b0;
            end
            default:
            begin
                nxt_st.phase = rbx_pkg::PH_DECODE;
            end
        endcase
    end

    always_ff @(posedge CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            st_ff <= '{phase: rbx_pkg::PH_DECODE, nop_cycle: 1'b0, busy: 1'b0, instr: 16'h0000,
                       taken: 1'b0, is_setbit: 1'b0, pc: PC_W'(rbx_pkg::PC_RESET), target: '0,
                       maddr: 12'h000, wdata: 8'h00, we: 1'b0, count: 32'h0000_0000};
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign PC_OUT          = st_ff.pc;
    assign MEM_ADDR_OUT    = st_ff.maddr;
    assign MEM_WE_OUT      = st_ff.we;
    assign MEM_WDATA_OUT   = st_ff.wdata;
    assign FLAGS_WE_OUT    = 1'b0;
    assign INSTR_READY_OUT = st_ff.phase == rbx_pkg::PH_DECODE && !st_ff.nop_cycle;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    logic accept;
    assign accept = INSTR_READY_OUT && INSTR_VALID_IN;

    AST_NEG_TAKEN: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        accept && INSTR_IN[15:8] == rbx_pkg::OPC_BRANCH_IF_NEGATIVE ##2 FLAG_N_IN |-> ##2 st_ff.nop_cycle)
        else $error("negative branch not taken");
    AST_NOCARRY_SKIP: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        accept && INSTR_IN[15:8] == rbx_pkg::OPC_BRANCH_IF_NO_CARRY ##2 FLAG_C_IN |-> ##2 !st_ff.nop_cycle)
        else $error("no-carry branch taken with carry set");
    AST_NOTNEG_SKIP: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        accept && INSTR_IN[15:8] == rbx_pkg::OPC_BRANCH_IF_NOT_NEGATIVE ##2 FLAG_N_IN |-> ##2 !st_ff.nop_cycle)
        else $error("not-negative branch taken with N set");
    AST_NOOVF_TAKEN: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        accept && INSTR_IN[15:8] == rbx_pkg::OPC_BRANCH_IF_NO_OVERFLOW ##2 !FLAG_OV_IN |-> ##2 st_ff.nop_cycle)
        else $error("no-overflow branch not taken");
    AST_NONZERO_SKIP: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        accept && INSTR_IN[15:8] == rbx_pkg::OPC_BRANCH_IF_NONZERO ##2 FLAG_Z_IN |-> ##2 !st_ff.nop_cycle)
        else $error("nonzero branch taken with Z set");
    AST_TARGET: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        accept && INSTR_IN[15:11] == rbx_pkg::OPC_BRANCH_ALWAYS |->
        ##4 PC_OUT == PC_W'($past(PC_OUT, 4) + 2 + {{(PC_W-12){$past(INSTR_IN[10], 4)}}, $past(INSTR_IN[10:0], 4), 1'b0}))
        else $error("branch target wrong");
    AST_NOP_LEN: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        $rose(st_ff.nop_cycle) |-> st_ff.nop_cycle [*4] ##1 !st_ff.nop_cycle)
        else $error("dead cycle not four phases");
    AST_ALWAYS_TAKEN: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        accept && INSTR_IN[15:11] == rbx_pkg::OPC_BRANCH_ALWAYS |-> ##4 st_ff.nop_cycle)
        else $error("unconditional branch not taken");
    AST_PHASE_ORDER: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        accept |-> ##1 st_ff.phase == rbx_pkg::PH_READ ##1 st_ff.phase == rbx_pkg::PH_PROCESS
        ##1 st_ff.phase == rbx_pkg::PH_WRITE ##1 st_ff.phase == rbx_pkg::PH_DECODE)
        else $error("phase order broken");
    AST_SETBIT_DATA: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        MEM_WE_OUT |-> MEM_WDATA_OUT == ($past(MEM_RDATA_IN, 2) | (8'h01 << $past(bidx, 2))))
        else $error("bit set data wrong");
    AST_BANK: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        st_ff.phase == rbx_pkg::PH_READ && is_setbit_w && st_ff.instr[rbx_pkg::BANK_BIT]
        |=> MEM_ADDR_OUT == {$past(bank_sel), $past(faddr)})
        else $error("banked address wrong");
    AST_INDEXED: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        st_ff.phase == rbx_pkg::PH_READ && !st_ff.instr[rbx_pkg::BANK_BIT] && ext_en
        && faddr <= rbx_pkg::INDEXED_LIMIT |=> MEM_ADDR_OUT == 12'($past(FSR2_IN) + {4'h0, $past(faddr)}))
        else $error("indexed address wrong");
    AST_FLAGS: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        !FLAGS_WE_OUT)
        else $error("flags written");

    AST_NEG_SKIP: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        accept && INSTR_IN[15:8] == rbx_pkg::OPC_BRANCH_IF_NEGATIVE ##2 !FLAG_N_IN |-> ##2 !st_ff.nop_cycle)
        else $error("negative branch taken with N clear");
    AST_NOCARRY_TAKEN: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        accept && INSTR_IN[15:8] == rbx_pkg::OPC_BRANCH_IF_NO_CARRY ##2 !FLAG_C_IN |-> ##2 st_ff.nop_cycle)
        else $error("no-carry branch not taken");
    AST_NOTNEG_TAKEN: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        accept && INSTR_IN[15:8] == rbx_pkg::OPC_BRANCH_IF_NOT_NEGATIVE ##2 !FLAG_N_IN |-> ##2 st_ff.nop_cycle)
        else $error("not-negative branch not taken");
    AST_NOOVF_SKIP: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        accept && INSTR_IN[15:8] == rbx_pkg::OPC_BRANCH_IF_NO_OVERFLOW ##2 FLAG_OV_IN |-> ##2 !st_ff.nop_cycle)
        else $error("no-overflow branch taken with OV set");
    AST_NONZERO_TAKEN: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        accept && INSTR_IN[15:8] == rbx_pkg::OPC_BRANCH_IF_NONZERO ##2 !FLAG_Z_IN |-> ##2 st_ff.nop_cycle)
        else $error("nonzero branch not taken");
    AST_SETBIT_LEN: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        accept && INSTR_IN[15:12] == rbx_pkg::OPC_SET_REGISTER_BIT
        |-> ##4 INSTR_READY_OUT && PC_OUT == PC_W'($past(PC_OUT, 4) + 2))
        else $error("single cycle word not done in four clocks");

    COV_TAKEN:   cover property (@(posedge CLK_IN) disable iff (!RESETN_IN) $rose(st_ff.nop_cycle));
    COV_SETBIT:  cover property (@(posedge CLK_IN) disable iff (!RESETN_IN) MEM_WE_OUT);
    COV_ALWAYS:  cover property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        accept && INSTR_IN[15:11] == rbx_pkg::OPC_BRANCH_ALWAYS);
    COV_INDEXED: cover property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        st_ff.phase == rbx_pkg::PH_READ && is_setbit_w && !st_ff.instr[rbx_pkg::BANK_BIT] && ext_en);
    COV_UNTAKEN: cover property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        st_ff.phase == rbx_pkg::PH_PROCESS && cond_op && !cond_ok);
endmodule // rbx_exec

// ### verif/rbx_mem_model.sv
// Behavioural banked data memory facing the execution block.
// Assumes one byte written per write pulse and reads answered in the same cycle.
`timescale 1ns/1ps
module rbx_mem_model
(
    input  wire logic        clk_in,
    input  wire logic [11:0] addr_in,
    input  wire logic        we_in,
    input  wire logic [7:0]  wdata_in,
    output logic      [7:0]  rdata_out
);
    logic [7:0] mem_ff [0:4095];

    // Address-derived fill from the low byte, so a wrong offset within a bank shows up as wrong old data
    initial
    begin
        for (int i = 0; i < 4096; i++)
            mem_ff[i] = 8'(i) ^ 8'h5A;
    end

    always @(posedge clk_in)
    begin
        if (we_in === 1'b1)
            mem_ff[addr_in] <= wdata_in;
    end

    assign rdata_out = mem_ff[addr_in];
endmodule // rbx_mem_model

// ### verif/tb_relative_branch_bit_set_exec.sv
// Self-checking bench for the branch and bit set execution block.
// Assumes the memory model's fill pattern and a 21-bit program counter.
`timescale 1ns/1ps
module tb_relative_branch_bit_set_exec;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        hsel = 1'b0;
    logic [7:0]  haddr = 8'h00;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        ivalid = 1'b0;
    logic [15:0] instr = 16'h0000;
    logic [3:0]  fl = 4'h0;
    logic [11:0] fsr2 = 12'h3A0;
    logic [31:0] hrdata, rd;
    logic        hreadyout, hresp, iready, mwe, flags_we;
    logic [20:0] pc, pc_m = 21'h0, pc_q[$];
    logic [11:0] maddr;
    logic [7:0]  mwdata, mrdata, shadow[int];
    logic [19:0] wr_q[$];
    logic [3:0]  bank_m = 4'h0;
    logic        ext_m = 1'b0;
    logic [7:0]  ops[5] = '{8'hE6, 8'hE3, 8'hE7, 8'hE5, 8'hE1};
    int          fidx[5] = '{3, 0, 3, 2, 1};
    int          miscompares = 0, checked = 0, seed = 35, cyc = 0, last_acc = 0, prev_gap = 0, gap_q[$];
    int          cnt_m = 0;

    rbx_exec #(.PC_W(21)) dut (.CLK_IN(clk), .RESETN_IN(resetn), .HSEL_IN(hsel), .HADDR_IN(haddr),
        .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HREADY_IN(hreadyout), .HWDATA_IN(hwdata),
        .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hreadyout), .HRESP_OUT(hresp), .INSTR_VALID_IN(ivalid),
        .INSTR_IN(instr), .FLAG_N_IN(fl[3]), .FLAG_OV_IN(fl[2]), .FLAG_Z_IN(fl[1]), .FLAG_C_IN(fl[0]),
        .FSR2_IN(fsr2), .MEM_RDATA_IN(mrdata), .INSTR_READY_OUT(iready), .PC_OUT(pc), .MEM_ADDR_OUT(maddr),
        .MEM_WE_OUT(mwe), .MEM_WDATA_OUT(mwdata), .FLAGS_WE_OUT(flags_we));
    rbx_mem_model mem (.clk_in(clk), .addr_in(maddr), .we_in(mwe), .wdata_in(mwdata), .rdata_out(mrdata));

    always #10 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task finish_test;
        $display("Comparisons %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Bounded wait for a high ready, then the edge that samples it
    task automatic wait_rdy(input bit use_instr);
        int k;
        for (k = 0; k < 20; k++)
        begin
            @(negedge clk);
            if ((use_instr ? iready : hreadyout) === 1'b1)
                break;
        end
        if (k == 20)
        begin
            miscompares++;
            finish_test();
        end
        @(posedge clk);
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        wait_rdy(0);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        // Data phase ends at this edge; read data is taken here
        wait_rdy(0);
        rd = hrdata;
        check(32'(hresp), 32'h0);
        prev_gap = 0;
    endtask

    function automatic logic [11:0] bs_addr(input logic [7:0] f, input logic a);
        if (a)
            return {bank_m, f};
        if (ext_m && f <= rbx_pkg::INDEXED_LIMIT)
            return fsr2 + {4'h0, f};
        return (f < rbx_pkg::ACCESS_SPLIT) ? {4'h0, f} : {rbx_pkg::ACCESS_HIGH_BANK, f};
    endfunction

    // -------------------------------------------------------------------
    // Driver: notes expected PC, spacing and memory writes per word
    // -------------------------------------------------------------------
    task automatic issue(input logic [15:0] w, input logic [3:0] f);
        logic        tk;
        logic        br;
        logic [20:0] off;
        logic [11:0] ad;
        logic [7:0]  ov;
        pc_q.push_back(pc_m);
        gap_q.push_back(prev_gap);
        instr <= w;
        ivalid <= 1'b1;
        fl <= 4'($random(seed));
        br = (w[15:11] == rbx_pkg::OPC_BRANCH_ALWAYS);
        case (w[15:8])
            rbx_pkg::OPC_BRANCH_IF_NEGATIVE:     tk = f[3];
            rbx_pkg::OPC_BRANCH_IF_NO_CARRY:     tk = !f[0];
            rbx_pkg::OPC_BRANCH_IF_NOT_NEGATIVE: tk = !f[3];
            rbx_pkg::OPC_BRANCH_IF_NO_OVERFLOW:  tk = !f[2];
            rbx_pkg::OPC_BRANCH_IF_NONZERO:      tk = !f[1];
            default:                             tk = br;
        endcase
        off = br ? {{10{w[10]}}, w[10:0]} : {{13{w[7]}}, w[7:0]};
        pc_m = tk ? pc_m + 21'h2 + (off << 1) : pc_m + 21'h2;
        prev_gap = tk ? 8 : 4;
        cnt_m++;
        if (w[15:12] == rbx_pkg::OPC_SET_REGISTER_BIT)
        begin
            ad = bs_addr(w[7:0], w[rbx_pkg::BANK_BIT]);
            ov = shadow.exists(ad) ? shadow[ad] : (ad[7:0] ^ 8'h5A);
            ov = ov | (8'h01 << w[11:9]);
            shadow[ad] = ov;
            wr_q.push_back({ad, ov});
        end
        wait_rdy(1);
        // Flags change after the accept and hold past the process edge
        fl <= f;
        repeat (2) @(posedge clk);
    endtask

    // -------------------------------------------------------------------
    // Monitor: takes the oldest note whenever a result appears
    // -------------------------------------------------------------------
    always @(negedge clk)
    begin
        if (resetn && ivalid && iready === 1'b1)
        begin
            check(32'(pc), 32'(pc_q.pop_front()));
            if (gap_q[0] != 0)
                check(32'(cyc + 1 - last_acc), 32'(gap_q[0]));
            void'(gap_q.pop_front());
            check(32'(flags_we), 32'h0);
            last_acc = cyc + 1;
        end
        if (resetn && mwe === 1'b1)
            check({12'h0, maddr, mwdata}, {12'h0, wr_q.pop_front()});
    end

    initial
    begin
        #200000;
        miscompares++;
        finish_test();
    end

    initial
    begin
        repeat (10) @(posedge clk);
        @(negedge clk);
        check({pc, mwe, iready}, {21'h0, 1'b0, 1'b1});
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        bus(0, rbx_pkg::ADDR_CTRL, 32'h0);
        check(rd, rbx_pkg::CTRL_RESET);
        bus(0, 8'h10, 32'h0);
        check(rd, 32'h0);
        // Each condition both ways, then offset limits and foreign words
        for (int op = 0; op < 5; op++)
            for (int p = 0; p < 2; p++)
            begin
                rd[3:0] = 4'($random(seed));
                rd[fidx[op]] = (op == 0) ? p[0] : !p[0];
                issue({ops[op], 8'($random(seed))}, rd[3:0]);
            end
        issue({8'hE1, 8'h80}, 4'h0);
        issue({8'hE1, 8'h7F}, 4'h0);
        issue({rbx_pkg::OPC_BRANCH_ALWAYS, 11'h400}, 4'hF);
        issue({rbx_pkg::OPC_BRANCH_ALWAYS, 11'h3FF}, 4'h0);
        issue(16'hE2FF, 4'h1);
        for (int i = 0; i < 20; i++)
            issue({ops[$unsigned($random(seed)) % 5], 8'($random(seed))}, 4'($random(seed)));
        for (int e = 0; e < 2; e++)
        begin
            ivalid <= 1'b0;
            ext_m = e[0];
            bank_m = 4'($random(seed));
            fsr2 <= 12'($random(seed));
            bus(1, rbx_pkg::ADDR_CTRL, (32'(bank_m) << rbx_pkg::CTRL_BANK_LSB) | 32'(ext_m));
            bus(0, rbx_pkg::ADDR_CTRL, 32'h0);
            check(rd, (32'(bank_m) << rbx_pkg::CTRL_BANK_LSB) | 32'(ext_m));
            issue({4'h8, 3'h7, 1'b0, 8'h5F}, 4'h0);
            issue({4'h8, 3'h0, 1'b0, 8'h60}, 4'hF);
            issue({8'hE1, 8'h02}, 4'h0);
            issue({4'h8, 3'h3, 1'b1, 8'h12}, 4'h5);
            for (int i = 0; i < 6; i++)
                issue({4'h8, 4'($random(seed)), 8'($random(seed))}, 4'($random(seed)));
            issue(16'h0000, 4'h0);
            ivalid <= 1'b0;
            repeat (8) @(posedge clk);
        end
        bus(1, rbx_pkg::ADDR_PC, 32'hFFFF_FFFF);
        bus(0, rbx_pkg::ADDR_PC, 32'h0);
        check(rd, 32'(pc_m));
        bus(0, rbx_pkg::ADDR_COUNT, 32'h0);
        check(rd, 32'(cnt_m));
        bus(0, rbx_pkg::ADDR_STATUS, 32'h0);
        check(rd, 32'h0);
        check(32'(wr_q.size()), 32'h0);
        finish_test();
    end
endmodule // tb_relative_branch_bit_set_exec
